// >>> src/plc_defs.svh
// constants for the programmable logic cell
`ifndef PLC_DEFS_SVH
`define PLC_DEFS_SVH
`define PLC_NUM_INPUTS   3
`define PLC_TABLE_BITS   8
`define PLC_TABLE_RESET  8'h00
`define PLC_SRC_WIDTH    5
`define PLC_SENSE_WIDTH  3
`define PLC_SRC_RESET    5'h00
`define PLC_SENSE_RESET  3'h1
`define PLC_HIST_RESET   19'h00000
`endif

// >>> src/plc_pkg.sv
// types for the programmable logic cell
package plc_pkg;
	typedef enum logic [2:0] {
		sense_low_level,
		sense_high_level,
		sense_fall,
		sense_rise,
		sense_both_transitions
	} plc_sense_t;

	typedef enum logic [4:0] {
		src_zero,
		src_line0,
		src_line1,
		src_line2,
		src_line3,
		src_user0,
		src_user1,
		src_user2,
		src_user3,
		src_counter0_start,
		src_counter1_start,
		src_counter0_end,
		src_counter1_end,
		src_cell0,
		src_cell1,
		src_exposure_start,
		src_exposure_end,
		src_awaiting_frame_trigger,
		src_capture_running
	} plc_source_t;

	typedef enum logic {
		table_value,
		table_enable
	} plc_table_t;
endpackage : plc_pkg

// >>> src/plc_input_sense.sv
// one table input: source select and level or edge sensitivity
`timescale 1ns/1ps
`include "plc_defs.svh"
module plc_input_sense
	import plc_pkg::*;
(
	input  wire logic                         clk,
	input  wire logic                         nrst,
	input  wire logic [18:0]                  sources,
	input  wire logic [`PLC_SRC_WIDTH-1:0]    source_sel,
	input  wire logic [`PLC_SENSE_WIDTH-1:0]  sense_sel,
	output logic                              active
);
	// history of every source, so a change of source never fakes an edge
	logic [18:0]  prev_sources;

	function automatic logic plc_pick(input logic [18:0] bits, input logic [`PLC_SRC_WIDTH-1:0] code);
		return (code < 5'h13) ? bits[code] : 1'b0;
	endfunction : plc_pick

	wire   picked      = plc_pick(sources, source_sel);
	wire   picked_prev = plc_pick(prev_sources, source_sel);
	wire   rise        = picked & ~picked_prev;
	wire   fall        = ~picked & picked_prev;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prev_sources <= `PLC_HIST_RESET;
		end else begin
			prev_sources <= sources;
		end
	end

	always_comb begin
		case (plc_sense_t'(sense_sel))
			sense_low_level:        active = ~picked;
			sense_high_level:       active = picked;
			sense_fall:             active = fall;
			sense_rise:             active = rise;
			sense_both_transitions: active = rise | fall;
			default:                active = 1'b0;
		endcase
	end

	rise_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
		(sense_sel == 3'h3 && $stable(source_sel) && $rose(picked)) |-> active)
		else $error("rising edge not reported");
	fall_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
		(sense_sel == 3'h2 && $stable(source_sel) && $fell(picked)) |-> active)
		else $error("falling edge not reported");
	pulse_once_a: assert property (@(posedge clk) disable iff (!nrst)
		(sense_sel == 3'h3 && active) ##1 ($stable(sense_sel) && $stable(source_sel)) |-> !active)
		else $error("edge pulse longer than one cycle");
endmodule : plc_input_sense

// >>> src/plc_cell.sv
// programmable logic cell: two shared-input lookup tables and an output flip-flop
`timescale 1ns/1ps
`include "plc_defs.svh"
module plc_cell
	import plc_pkg::*;
(
	input  wire logic                         clk,
	input  wire logic                         nrst,
	input  wire logic [3:0]                   line_in,
	input  wire logic [3:0]                   user_out,
	input  wire logic [1:0]                   counter_start,
	input  wire logic [1:0]                   counter_end,
	input  wire logic                         other_cell_out,
	input  wire logic                         cell_is_one,
	input  wire logic                         exposure_start,
	input  wire logic                         exposure_end,
	input  wire logic                         awaiting_frame_trigger,
	input  wire logic                         capture_running,
	input  wire logic                         table_select,
	input  wire logic [1:0]                   table_input_index,
	input  wire logic                         input_cfg_write,
	input  wire logic [`PLC_SRC_WIDTH-1:0]    table_input_source,
	input  wire logic [`PLC_SENSE_WIDTH-1:0]  table_input_sensitivity,
	input  wire logic [2:0]                   truth_row_index,
	input  wire logic                         truth_row_write,
	input  wire logic                         truth_row_bit,
	input  wire logic                         truth_word_write,
	input  wire logic [`PLC_TABLE_BITS-1:0]   truth_table_word,
	output logic [`PLC_TABLE_BITS-1:0]        value_table,
	output logic [`PLC_TABLE_BITS-1:0]        enable_table,
	output logic                              cell_out
);
	//----------------------------------------------------------------
	// configuration storage
	//----------------------------------------------------------------
	logic [`PLC_SRC_WIDTH-1:0]    src_sel   [`PLC_NUM_INPUTS];
	logic [`PLC_SENSE_WIDTH-1:0]  sense_sel [`PLC_NUM_INPUTS];
	logic [`PLC_NUM_INPUTS-1:0]   in_active;
	logic [18:0]                  sources;

	// a whole-table write wins over a row write in the same cycle
	function automatic logic [`PLC_TABLE_BITS-1:0] plc_table_update(
		input logic [`PLC_TABLE_BITS-1:0] cur,
		input logic                       word_wr,
		input logic [`PLC_TABLE_BITS-1:0] word,
		input logic                       row_wr,
		input logic [2:0]                 row,
		input logic                       bit_val);
		logic [`PLC_TABLE_BITS-1:0] t;
		t = cur;
		if (word_wr) begin
			t = word;
		end else if (row_wr) begin
			t[row] = bit_val;
		end
		return t;
	endfunction : plc_table_update

	wire sel_value  = (plc_table_t'(table_select) == table_value);
	wire sel_enable = (plc_table_t'(table_select) == table_enable);
	// index 3 addresses no input and is ignored
	wire cfg_take   = input_cfg_write && (table_input_index < 2'h3);

	wire [`PLC_TABLE_BITS-1:0] next_value_table = sel_value ? plc_table_update(value_table, truth_word_write,
		truth_table_word, truth_row_write, truth_row_index, truth_row_bit) : value_table;
	wire [`PLC_TABLE_BITS-1:0] next_enable_table = sel_enable ? plc_table_update(enable_table, truth_word_write,
		truth_table_word, truth_row_write, truth_row_index, truth_row_bit) : enable_table;

	// readback comes straight from the table registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			value_table  <= `PLC_TABLE_RESET;
			enable_table <= `PLC_TABLE_RESET;
		end else begin
			value_table  <= next_value_table;
			enable_table <= next_enable_table;
		end
	end

	// one set of input selections regardless of table_select
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < `PLC_NUM_INPUTS; i++) begin
				src_sel[i]   <= `PLC_SRC_RESET;
				sense_sel[i] <= `PLC_SENSE_RESET;
			end
		end else if (cfg_take) begin
			src_sel[table_input_index]   <= table_input_source;
			sense_sel[table_input_index] <= table_input_sensitivity;
		end
	end

	//----------------------------------------------------------------
	// inputs
	//----------------------------------------------------------------
	// cell_is_one decides which of codes 13 and 14 is this cell's own output
	assign sources = {capture_running, awaiting_frame_trigger, exposure_end, exposure_start,
		cell_is_one ? cell_out : other_cell_out, cell_is_one ? other_cell_out : cell_out,
		counter_end, counter_start, user_out, line_in, 1'b0};

	for (genvar g = 0; g < `PLC_NUM_INPUTS; g++) begin : g_in
		plc_input_sense u_sense (
			.clk        (clk),
			.nrst       (nrst),
			.sources    (sources),
			.source_sel (src_sel[g]),
			.sense_sel  (sense_sel[g]),
			.active     (in_active[g])
		);
	end

	//----------------------------------------------------------------
	// lookup and output flip-flop
	//----------------------------------------------------------------
	wire [2:0] row_now   = in_active;
	wire       value_bit = value_table[row_now];
	wire       load_bit  = enable_table[row_now];
	// an all-ones enable table loads every cycle, so the flip-flop follows the value bit one cycle later

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cell_out <= 1'b0;
		end else if (load_bit) begin
			cell_out <= value_bit;
		end
	end

	//----------------------------------------------------------------
	// checks
	//----------------------------------------------------------------

	hold_when_off_a: assert property (@(posedge clk) disable iff (!nrst)
		!load_bit |=> $stable(cell_out))
		else $error("output changed while enable false");
	load_when_on_a: assert property (@(posedge clk) disable iff (!nrst)
		load_bit |=> (cell_out == $past(value_bit)))
		else $error("output did not load value");
	transparent_a: assert property (@(posedge clk) disable iff (!nrst)
		(enable_table == 8'hFF && $past(enable_table) == 8'hFF) |-> (cell_out == $past(value_bit)))
		else $error("output not following value table");
	word_write_a: assert property (@(posedge clk) disable iff (!nrst)
		(truth_word_write && sel_value) |=> (value_table == $past(truth_table_word)))
		else $error("whole-table write lost");
	row_write_a: assert property (@(posedge clk) disable iff (!nrst)
		(truth_row_write && !truth_word_write && sel_enable) |=>
		(enable_table[$past(truth_row_index)] == $past(truth_row_bit)))
		else $error("row write lost");
	other_table_a: assert property (@(posedge clk) disable iff (!nrst)
		sel_value |=> $stable(enable_table))
		else $error("write hit unselected table");
	shared_inputs_a: assert property (@(posedge clk) disable iff (!nrst)
		(input_cfg_write && table_input_index == 2'd1) |=> (src_sel[1] == $past(table_input_source)))
		else $error("input selection not stored");
	reset_clear_a: assert property (@(posedge clk) $rose(nrst) |-> (cell_out == 1'b0))
		else $error("output not cleared by reset");

	//----------------------------------------------------------------
	// checks: table writes
	//----------------------------------------------------------------
	enable_word_a: assert property (@(posedge clk) disable iff (!nrst)
		(truth_word_write && sel_enable) |=> (enable_table == $past(truth_table_word)))
		else $error("whole-table write to enable table lost");

	value_row_a: assert property (@(posedge clk) disable iff (!nrst)
		(truth_row_write && !truth_word_write && sel_value) |=>
		(value_table[$past(truth_row_index)] == $past(truth_row_bit)))
		else $error("row write to value table lost");

	word_over_row_a: assert property (@(posedge clk) disable iff (!nrst)
		(truth_word_write && truth_row_write && sel_value) |=> (value_table == $past(truth_table_word)))
		else $error("row write beat whole-table write");

	value_untouched_a: assert property (@(posedge clk) disable iff (!nrst)
		sel_enable |=> $stable(value_table))
		else $error("write hit unselected value table");

	tables_reset_a: assert property (@(posedge clk)
		$rose(nrst) |-> (value_table == `PLC_TABLE_RESET && enable_table == `PLC_TABLE_RESET))
		else $error("tables not cleared by reset");

	//----------------------------------------------------------------
	// checks: shared input selections
	//----------------------------------------------------------------
	input_zero_a: assert property (@(posedge clk) disable iff (!nrst)
		(input_cfg_write && table_input_index == 2'h0) |=>
		(src_sel[0] == $past(table_input_source) && sense_sel[0] == $past(table_input_sensitivity)))
		else $error("input 0 selection not stored");

	input_two_a: assert property (@(posedge clk) disable iff (!nrst)
		(input_cfg_write && table_input_index == 2'h2) |=>
		(src_sel[2] == $past(table_input_source) && sense_sel[2] == $past(table_input_sensitivity)))
		else $error("input 2 selection not stored");

	index_three_a: assert property (@(posedge clk) disable iff (!nrst)
		(input_cfg_write && table_input_index == 2'h3) |=>
		($stable(src_sel[0]) && $stable(src_sel[1]) && $stable(src_sel[2])))
		else $error("index 3 changed a selection");

	input_hold_a: assert property (@(posedge clk) disable iff (!nrst)
		!input_cfg_write |=> ($stable(src_sel[0]) && $stable(src_sel[1]) && $stable(src_sel[2]) &&
		$stable(sense_sel[0]) && $stable(sense_sel[1]) && $stable(sense_sel[2])))
		else $error("selection changed without a write");

	//----------------------------------------------------------------
	// checks: lookup row order
	//----------------------------------------------------------------
	and_example_a: assert property (@(posedge clk) disable iff (!nrst)
		(value_table == 8'hC0 && load_bit) |=> (cell_out == $past(in_active[2] & in_active[1])))
		else $error("row order wrong for input1 and input2");
endmodule : plc_cell

// >>> tb/plc_source_model.sv
// stand-in for the internal signals that feed the logic cell
`timescale 1ns/1ps
module plc_source_model (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [16:0] pattern,
	output logic      [16:0] sig
);
	// internal signals only move just after a clock edge
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			sig <= 17'h00000;
		else
			sig <= pattern;
	end
endmodule : plc_source_model

// >>> tb/plc_cell_test.sv
// self-checking bench for the programmable logic cell
`timescale 1ns/1ps
`include "plc_defs.svh"
module plc_cell_test;
	typedef struct packed {
		logic                        sel, cw, rw, rbit, ww, one;
		logic [1:0]                  idx;
		logic [`PLC_SRC_WIDTH-1:0]   src;
		logic [`PLC_SENSE_WIDTH-1:0] sns;
		logic [2:0]                  row;
		logic [`PLC_TABLE_BITS-1:0]  word;
	} plc_ctl_t;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [16:0] pattern = 17'h00000;
	logic [16:0] sig, e;
	plc_ctl_t    ctl = '0;
	plc_ctl_t    n_ctl = '0;
	logic [7:0]  vt_o, et_o, m_vt, m_et, t;
	logic        c_out, m_out, c, p;
	logic [4:0]  m_src [3];
	logic [2:0]  m_sns [3];
	logic [2:0]  li;
	logic [18:0] s, ps;
	logic [31:0] rs = 32'h534FB183;
	logic [31:0] v;
	logic [16:0] q [$];
	int          n_errors = 0;
	int          n_checks = 0;

	always #5 clk = ~clk;

	plc_source_model src_model (.clk(clk), .nrst(nrst), .pattern(pattern), .sig(sig));

	plc_cell dut (.clk(clk), .nrst(nrst), .line_in(sig[3:0]), .user_out(sig[7:4]),
		.counter_start(sig[9:8]), .counter_end(sig[11:10]), .other_cell_out(sig[12]), .cell_is_one(ctl.one),
		.exposure_start(sig[13]), .exposure_end(sig[14]), .awaiting_frame_trigger(sig[15]),
		.capture_running(sig[16]), .table_select(ctl.sel), .table_input_index(ctl.idx),
		.input_cfg_write(ctl.cw), .table_input_source(ctl.src), .table_input_sensitivity(ctl.sns),
		.truth_row_index(ctl.row), .truth_row_write(ctl.rw), .truth_row_bit(ctl.rbit),
		.truth_word_write(ctl.ww), .truth_table_word(ctl.word), .value_table(vt_o),
		.enable_table(et_o), .cell_out(c_out));

	function automatic logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : xs

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test

	task automatic step();
		@(posedge clk);
		ctl <= n_ctl;
		pattern <= xs();
		n_ctl.cw = 1'b0;
		n_ctl.rw = 1'b0;
		n_ctl.ww = 1'b0;
	endtask : step

	// reference: inputs seen during a cycle decide the output at its closing edge
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			m_src = '{default: 5'h00};
			m_sns = '{default: 3'h1};
			{m_vt, m_et, m_out, ps} = '0;
		end else begin
			s = {sig[16:13], ctl.one ? m_out : sig[12], ctl.one ? sig[12] : m_out, sig[11:0], 1'b0};
			for (int i = 0; i < 3; i++) begin
				c = (m_src[i] < 5'h13) && s[m_src[i]];
				p = (m_src[i] < 5'h13) && ps[m_src[i]];
				li[i] = m_sns[i] == 3'h0 ? !c : m_sns[i] == 3'h1 ? c : m_sns[i] == 3'h2 ? p && !c :
					m_sns[i] == 3'h3 ? !p && c : m_sns[i] == 3'h4 ? p != c : 1'b0;
			end
			if (m_et[li])
				m_out = m_vt[li];
			ps = s;
			if (ctl.cw && ctl.idx != 2'h3) begin
				m_src[ctl.idx] = ctl.src;
				m_sns[ctl.idx] = ctl.sns;
			end
			t = ctl.sel ? m_et : m_vt;
			if (ctl.ww)
				t = ctl.word;
			else if (ctl.rw)
				t[ctl.row] = ctl.rbit;
			if (ctl.sel)
				m_et = t;
			else
				m_vt = t;
			q.push_back({m_out, m_vt, m_et});
		end
	end

	always @(negedge clk) begin
		if (nrst && q.size() > 0) begin
			e = q.pop_front();
			check({7'h00, c_out}, {7'h00, e[16]});
			check(vt_o, e[15:8]);
			check(et_o, e[7:0]);
		end
	end

	initial begin
		#100000;
		n_errors++;
		stop_test();
	end

	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		for (int r = 0; r < 13; r++) begin
			// rounds 4 and 12 pick both cell outputs, once under each strap setting
			n_ctl.one = r[2] & ~r[3];
			// enable table off while the shared inputs are rewired
			n_ctl.sel = 1'b1;
			n_ctl.ww = 1'b1;
			n_ctl.word = 8'h00;
			step();
			for (int i = 0; i < 4; i++) begin
				n_ctl.cw = 1'b1;
				n_ctl.idx = 2'(i);
				n_ctl.src = r ? 5'((3 * r + i) % 24) : 5'(i + 1);
				n_ctl.sns = r ? 3'((r + 7 * i) % 8) : 3'h1;
				step();
			end
			v = xs();
			n_ctl.sel = 1'b0;
			for (int k = 0; k < 8 && r[0]; k++) begin
				n_ctl.rw = 1'b1;
				n_ctl.row = 3'(k);
				n_ctl.rbit = v[k];
				n_ctl.ww = (k == 7);
				n_ctl.word = v[15:8];
				step();
			end
			n_ctl.ww = !r[0];
			n_ctl.word = r ? v[7:0] : 8'hC0;
			step();
			n_ctl.sel = 1'b1;
			n_ctl.ww = 1'b1;
			n_ctl.word = r ? v[23:16] : 8'hFF;
			step();
			repeat (40) step();
			$display("round %0d done", r);
		end
		stop_test();
	end
endmodule : plc_cell_test
